/* File: hw/slate_tone_control.sv */
// Purpose: Slide switch control, tone generator and signal insertion for talkback and tone
// Assumes: Switch, encoder and transport pins are asynchronous; audio frames arrive with sample_valid
// Notes:   Registers on APB with zero wait states; unmapped addresses answer with pslverr
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module slate_tone_control
  import slate_tone_pkg::*;
#(
  parameter int HOLD_CYCLES     = HOLD_CYC,
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int IDENT_CYCLES    = IDENT_CYC
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Operator controls (asynchronous pins)
  input  wire logic              switch_left,
  input  wire logic              switch_right,
  input  wire logic              select_encoder_held,
  input  wire logic              transport_up,
  input  wire logic              transport_down,
  // Indicators and transport commands
  output logic                   talkback_led,
  output logic                   tone_led,
  output logic                   record_start,
  output logic                   play_start,
  // Audio in
  input  wire logic              sample_valid,
  input  wire dest_frame_t       program_in,
  input  wire stereo_t           headphone_mix,
  input  wire sample_t           talkback_in,
  input  wire sample_t           return_feed_source,
  // Audio out
  output dest_frame_t            dest_out,
  output dest_frame_t            aes_out,
  output stereo_t                headphone_out
);

  // ****************************************
  // Synchronisers and debounce
  // ****************************************
  localparam int NPIN = 5;
  typedef enum {
    IDLE, TB_PRESS, TB_LATCHED, TB_MOMENT, TB_OFF_PRESS,
    TONE_PRESS, TONE_LATCHED, TONE_OFF_PRESS
  } sw_state_t;

  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] db_r;
  logic [NPIN-1:0] db_prev_r;
  wire  [NPIN-1:0] pins = {transport_down, transport_up, select_encoder_held, switch_right, switch_left};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      db_prev_r <= '0;
    end
    else
    begin
      sync1_r   <= pins;
      sync2_r   <= sync1_r;
      db_prev_r <= db_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_db
      logic [23:0] cnt_r;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_r   <= '0;
          db_r[g] <= 1'b0;
        end
        else if (sync2_r[g] == db_r[g])
          cnt_r <= '0;
        else if (cnt_r >= 24'(DEBOUNCE_CYCLES - 1))
        begin
          cnt_r   <= '0;
          db_r[g] <= sync2_r[g];
        end
        else
          cnt_r <= cnt_r + 24'h000001;
      end
    end
  endgenerate

  // one switch, two sides and rest
  wire left_db    = db_r[0] & ~db_r[1];
  wire right_db   = db_r[1] & ~db_r[0];
  wire left_rise  = db_r[0] & ~db_prev_r[0];
  wire right_rise = db_r[1] & ~db_prev_r[1];
  wire enc_db     = db_r[2];
  wire up_rise    = db_r[3] & ~db_prev_r[3];
  wire down_rise  = db_r[4] & ~db_prev_r[4];

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0]       level_r;
  logic             mode_ident_r;
  logic             hp_src_return_r;
  logic             hp_to_aux3_r;
  logic             hp_to_aux4_r;
  logic [9:0]       freq_r;
  logic [NDEST-1:0] slate_mask_r;
  logic [NDEST-1:0] tone_mask_r;
  sw_state_t        state_r;
  logic             ident_r;

  wire wr_en  = psel & penable & pwrite;
  wire hit_ctrl  = (paddr == ADDR_CTRL);
  wire hit_freq  = (paddr == ADDR_FREQ);
  wire hit_smask = (paddr == ADDR_SLATE_MASK);
  wire hit_tmask = (paddr == ADDR_TONE_MASK);
  wire hit_stat  = (paddr == ADDR_STATUS);
  wire hit_any   = hit_ctrl | hit_freq | hit_smask | hit_tmask | hit_stat;

  // level clamped to the 20 dB range
  wire [4:0] level_wr = (pwdata[CTRL_LEVEL_LSB +: 5] > LEVEL_MAX) ? LEVEL_MAX : pwdata[CTRL_LEVEL_LSB +: 5];
  // frequency held in 10 Hz units within range
  wire [9:0] freq_wr  = (pwdata[9:0] < FREQ_MIN) ? FREQ_MIN :
                        (pwdata[9:0] > FREQ_MAX) ? FREQ_MAX : pwdata[9:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_r         <= LEVEL_RST;
      freq_r          <= FREQ_RST;
      mode_ident_r    <= 1'b0;
      hp_src_return_r <= 1'b0;
      hp_to_aux3_r    <= 1'b0;
      hp_to_aux4_r    <= 1'b0;
      slate_mask_r    <= SLATE_MASK_RST;
      tone_mask_r     <= TONE_MASK_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
      begin
        level_r         <= level_wr;
        mode_ident_r    <= pwdata[CTRL_MODE_BIT];
        hp_src_return_r <= pwdata[CTRL_HPRET_BIT];
        hp_to_aux3_r    <= pwdata[CTRL_HP_AUX3_BIT];
        hp_to_aux4_r    <= pwdata[CTRL_HP_AUX4_BIT];
      end
      else if (hit_freq)
        freq_r <= freq_wr;
      else if (hit_smask)
        slate_mask_r <= pwdata[NDEST-1:0];
      else if (hit_tmask)
        tone_mask_r <= pwdata[NDEST-1:0];
    end
  end

  wire tb_on   = (state_r == TB_PRESS) | (state_r == TB_LATCHED) | (state_r == TB_MOMENT);
  wire tone_on = (state_r == TONE_PRESS) | (state_r == TONE_LATCHED);

  wire [31:0] ctrl_rd = {23'h000000, hp_to_aux4_r, hp_to_aux3_r, hp_src_return_r, mode_ident_r, level_r};
  wire [31:0] stat_rd = {28'h0000000, ident_r, state_r == TONE_LATCHED, tone_on, tb_on};

  always_comb
  begin
    if (hit_ctrl)
      prdata = ctrl_rd;
    else if (hit_freq)
      prdata = {22'h000000, freq_r};
    else if (hit_smask)
      prdata = {20'h00000, slate_mask_r};
    else if (hit_tmask)
      prdata = {20'h00000, tone_mask_r};
    else if (hit_stat)
      prdata = stat_rd;
    else
      prdata = 32'h00000000;
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ****************************************
  // Switch state machine
  // ****************************************
  logic [23:0] hold_cnt_r;
  sw_state_t   state_nxt;
  wire hold_done = (hold_cnt_r >= 24'(HOLD_CYCLES));

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      IDLE:
        if (left_rise)
          state_nxt = TB_PRESS;
        else if (right_rise)
          state_nxt = TONE_PRESS;
      TB_PRESS:
        if (!left_db)
          state_nxt = TB_LATCHED;
        else if (hold_done)
          state_nxt = TB_MOMENT;
      TB_LATCHED:
        if (left_rise)
          state_nxt = TB_OFF_PRESS;
        else if (right_rise)
          state_nxt = TONE_PRESS;
      TB_MOMENT:
        if (!left_db)
          state_nxt = IDLE;
      TB_OFF_PRESS:
        if (!left_db)
          state_nxt = IDLE;
      // latch only after a long hold
      TONE_PRESS:
        if (!right_db)
          state_nxt = hold_done ? TONE_LATCHED : IDLE;
        else if (left_rise)
          state_nxt = TB_PRESS;
      // next right slide turns tone off
      TONE_LATCHED:
        if (right_rise)
          state_nxt = TONE_OFF_PRESS;
        else if (left_rise)
          state_nxt = TB_PRESS;
      TONE_OFF_PRESS:
        if (!right_db)
          state_nxt = IDLE;
      default:
        state_nxt = IDLE;
    endcase
  end

  wire enter_tone = (state_nxt == TONE_PRESS) & (state_r != TONE_PRESS);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= IDLE;
      hold_cnt_r <= '0;
      ident_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      // hold time counted from the clock
      if (state_nxt != state_r)
        hold_cnt_r <= '0;
      else if (!hold_done)
        hold_cnt_r <= hold_cnt_r + 24'h000001;
      if (enter_tone)
        ident_r <= enc_db | mode_ident_r;
    end
  end

  assign talkback_led = tb_on;
  assign tone_led     = tone_on;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      record_start <= 1'b0;
      play_start   <= 1'b0;
    end
    else
    begin
      record_start <= up_rise;
      play_start   <= down_rise;
    end
  end

  // ****************************************
  // Tone generator
  // ****************************************
  localparam logic [11:0] SINE_Q [16] = '{12'h064, 12'h12c, 12'h1f1, 12'h2b2, 12'h36c, 12'h41c, 12'h4c3,
    12'h55f, 12'h5ed, 12'h66d, 12'h6db, 12'h73a, 12'h787, 12'h7c2, 12'h7e9, 12'h7fd};
  localparam logic [15:0] GAIN_DB [21] = '{16'h0800, 16'h08fa, 16'h0a12, 16'h0b4d, 16'h0cae, 16'h0e3a,
    16'h0ff6, 16'h11e9, 16'h1418, 16'h168c, 16'h194c, 16'h1c62, 16'h1fd9, 16'h23bc, 16'h2818, 16'h2cfc,
    16'h327a, 16'h38a2, 16'h3f8b, 16'h474b, 16'h5000};

  logic [PHASE_W-1:0] phase_r;
  logic [23:0]        ident_cnt_r;
  logic               ident_gap_r;

  wire [PHASE_W-1:0] phase_inc = PHASE_W'(freq_r * PHASE_PER_STEP);
  wire [3:0]  q_idx  = phase_r[PHASE_W-2] ? ~phase_r[PHASE_W-3 -: 4] : phase_r[PHASE_W-3 -: 4];
  wire [27:0] scaled = 28'(SINE_Q[q_idx] * GAIN_DB[level_r]);
  wire [15:0] mag    = scaled[26:11];
  wire sample_t tone_s = phase_r[PHASE_W-1] ? -sample_t'(mag) : sample_t'(mag);
  // left channel gated off during gap
  wire sample_t tone_l = (ident_r & ident_gap_r) ? '0 : tone_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r     <= '0;
      ident_cnt_r <= '0;
      ident_gap_r <= 1'b0;
    end
    else
    begin
      if (sample_valid)
        phase_r <= phase_r + phase_inc;
      if (!tone_on || ident_cnt_r >= 24'(IDENT_CYCLES - 1))
      begin
        ident_cnt_r <= '0;
        ident_gap_r <= tone_on & ~ident_gap_r;
      end
      else
        ident_cnt_r <= ident_cnt_r + 24'h000001;
    end
  end

  // ****************************************
  // Insertion
  // ****************************************
  function automatic sample_t sat_add(input sample_t a, input sample_t b);
    logic signed [SAMPLE_W:0] s;
    s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
    if (s[SAMPLE_W] != s[SAMPLE_W-1])
      sat_add = s[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    else
      sat_add = s[SAMPLE_W-1:0];
  endfunction

  dest_frame_t prog_f;
  dest_frame_t dest_nxt;
  dest_frame_t aes_nxt;
  stereo_t     hp_prog;
  stereo_t     hp_nxt;

  always_comb
  begin
    prog_f = program_in;
    // headphone copy without the return feed
    if (hp_to_aux3_r)
      prog_f.dest[DST_AUX_THIRD] = sat_add(program_in.dest[DST_AUX_THIRD], headphone_mix.left);
    if (hp_to_aux4_r)
      prog_f.dest[DST_AUX_FOURTH] = sat_add(program_in.dest[DST_AUX_FOURTH], headphone_mix.right);
    dest_nxt = prog_f;
    aes_nxt  = prog_f;
    for (int i = 0; i < NDEST; i++)
    begin
      if (tb_on && slate_mask_r[i])
        dest_nxt.dest[i] = talkback_in;
      else if (tone_on && tone_mask_r[i])
      begin
        dest_nxt.dest[i] = (i == DST_MAIN_L) ? tone_l : tone_s;
        aes_nxt.dest[i]  = dest_nxt.dest[i];
      end
    end
    hp_prog = hp_src_return_r ? stereo_t'{left: return_feed_source, right: return_feed_source} : headphone_mix;
    hp_nxt  = hp_prog;
    if (tb_on)
      hp_nxt = '{left: talkback_in, right: talkback_in};
    // tone kept out when return is monitored
    else if (tone_on && !hp_src_return_r)
      hp_nxt = '{left: tone_l, right: tone_s};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dest_out      <= '0;
      aes_out       <= '0;
      headphone_out <= '0;
    end
    else if (sample_valid)
    begin
      dest_out      <= dest_nxt;
      aes_out       <= aes_nxt;
      headphone_out <= hp_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_left_on;
    @(posedge clk) disable iff (!rst_n) (state_r == IDLE && left_rise) |=> talkback_led ##1 (talkback_led || !left_db);
  endproperty
  a_left_on: assert property (p_left_on) else $error("talkback did not start on left slide");

  property p_moment_off;
    @(posedge clk) disable iff (!rst_n) (state_r == TB_MOMENT && !left_db) |=> !talkback_led;
  endproperty
  a_moment_off: assert property (p_moment_off) else $error("momentary talkback stayed on");

  property p_led_match;
    @(posedge clk) disable iff (!rst_n) $rose(talkback_led) |-> $past(left_rise);
  endproperty
  a_led_match: assert property (p_led_match) else $error("talkback indicator rose without left slide");

  property p_tone_latch;
    @(posedge clk) disable iff (!rst_n) (state_r == TONE_PRESS && !right_db && hold_done) |=> state_r == TONE_LATCHED;
  endproperty
  a_tone_latch: assert property (p_tone_latch) else $error("long tone hold did not latch");

  property p_tone_off;
    @(posedge clk) disable iff (!rst_n) (state_r == TONE_LATCHED && right_rise) |=> !tone_led;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("latched tone not turned off");

  property p_ranges;
    @(posedge clk) disable iff (!rst_n) level_r <= LEVEL_MAX && freq_r >= FREQ_MIN && freq_r <= FREQ_MAX;
  endproperty
  a_ranges: assert property (p_ranges) else $error("tone setting outside range");

  property p_exclusive;
    @(posedge clk) disable iff (!rst_n) !(talkback_led && tone_led);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("talkback and tone both active");

  property p_aes_clean;
    @(posedge clk) disable iff (!rst_n) (sample_valid && tb_on) |=> aes_out == $past(prog_f);
  endproperty
  a_aes_clean: assert property (p_aes_clean) else $error("talkback reached digital outputs");

  property p_record;
    @(posedge clk) disable iff (!rst_n) up_rise |=> record_start ##1 !record_start;
  endproperty
  a_record: assert property (p_record) else $error("record command not issued once");

  property p_hp_tb;
    @(posedge clk) disable iff (!rst_n) (sample_valid && tb_on) |=> headphone_out.left == $past(talkback_in);
  endproperty
  a_hp_tb: assert property (p_hp_tb) else $error("talkback missing from headphones");

  c_tb_latch: cover property (@(posedge clk) disable iff (!rst_n) state_r == TB_PRESS ##1 state_r == TB_LATCHED);
  c_tb_moment: cover property (@(posedge clk) disable iff (!rst_n) state_r == TB_MOMENT);
  c_tone_latch: cover property (@(posedge clk) disable iff (!rst_n) state_r == TONE_LATCHED);
  c_ident: cover property (@(posedge clk) disable iff (!rst_n) tone_on && ident_r && ident_gap_r);

endmodule

/* File: inc/slate_tone_pkg.sv */
// Purpose: Shared constants and carriers for the talkback and tone insertion block
// Assumes: 10 MHz system clock, APB register access, 16-bit audio samples
// Notes:   Register words are aligned 32-bit locations
package slate_tone_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int HOLD_MS       = 1000;
  localparam int DEBOUNCE_MS   = 10;
  localparam int IDENT_HALF_MS = 250;
  localparam int HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
  localparam int DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int IDENT_CYC     = CLK_HZ / 1000 * IDENT_HALF_MS;
  localparam int SAMPLE_HZ     = 48_000;

  // ****************************************
  // Audio carrier
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int NDEST    = 12;
  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef struct packed {
    logic [NDEST-1:0][SAMPLE_W-1:0] dest;
  } dest_frame_t;
  typedef struct packed {
    sample_t left;
    sample_t right;
  } stereo_t;

  // Destination bit order
  localparam int DST_MAIN_L     = 0;
  localparam int DST_MAIN_R     = 1;
  localparam int DST_AUX_FIRST  = 2;
  localparam int DST_AUX_SECOND = 3;
  localparam int DST_AUX_THIRD  = 4;
  localparam int DST_AUX_FOURTH = 5;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_FREQ       = 12'h004;
  localparam logic [11:0] ADDR_SLATE_MASK = 12'h008;
  localparam logic [11:0] ADDR_TONE_MASK  = 12'h00c;
  localparam logic [11:0] ADDR_STATUS     = 12'h010;

  localparam int CTRL_LEVEL_LSB   = 0;
  localparam int CTRL_MODE_BIT    = 5;
  localparam int CTRL_HPRET_BIT   = 6;
  localparam int CTRL_HP_AUX3_BIT = 7;
  localparam int CTRL_HP_AUX4_BIT = 8;

  localparam logic [4:0]       LEVEL_RST        = 5'h00;
  localparam logic [4:0]       LEVEL_MAX        = 5'h14;
  localparam logic [9:0]       FREQ_RST         = 10'h064;
  localparam logic [9:0]       FREQ_MIN         = 10'h00a;
  localparam logic [9:0]       FREQ_MAX         = 10'h3e8;
  localparam logic [NDEST-1:0] SLATE_MASK_RST   = 12'h03f;
  localparam logic [NDEST-1:0] TONE_MASK_RST    = 12'hfff;
  localparam int               FREQ_STEP_HZ     = 10;
  localparam int               PHASE_W          = 24;
  localparam logic [23:0]      PHASE_PER_STEP   = 24'((64'(FREQ_STEP_HZ) << PHASE_W) / SAMPLE_HZ);

endpackage

/* File: test/operator_panel.sv */
// Purpose: Operator slide switch model with contact bounce
// Assumes: pos 0 rest, 1 left, 2 right
// Notes:   Each move chatters six cycles on the moving contact
`timescale 1ns/100ps
module operator_panel (
  // Clock
  input  wire logic       clk,
  // Wanted position
  input  wire logic [1:0] pos,
  // Switch contacts
  output logic            sw_l,
  output logic            sw_r
);
  logic [1:0] last_r;
  logic [1:0] prev_r;
  int         bnc;
  logic       mv_l;
  logic       mv_r;

  assign mv_l = (bnc > 0) && (pos == 2'h1 || prev_r == 2'h1);
  assign mv_r = (bnc > 0) && (pos == 2'h2 || prev_r == 2'h2);
  initial
  begin
    {sw_l, sw_r, last_r, prev_r} = 6'h00;
    bnc = 0;
  end
  always @(posedge clk)
  begin
    last_r <= pos;
    prev_r <= (pos != last_r) ? last_r : prev_r;
    bnc    <= (pos != last_r) ? 6 : (bnc > 0 ? bnc - 1 : 0);
    sw_l   <= mv_l ? ~sw_l : (pos == 2'h1);
    sw_r   <= mv_r ? ~sw_r : (pos == 2'h2);
  end
endmodule

/* File: test/slate_tone_control_tb_top.sv */
// Purpose: Self-checking bench for switch, registers, insertion, transport
// Assumes: Shortened hold and debounce counts
// Notes:   Tone samples are not modelled, only where tone may stand
`timescale 1ns/100ps
module slate_tone_control_tb_top
  import slate_tone_pkg::*;
;
  localparam int HOLD = 200;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        sample_valid, enc, tled, oled, rec, ply, sw_l, sw_r;
  logic [11:0] paddr, smask, tmask;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [1:0]  pos, tp;
  dest_frame_t prog, dout, aout;
  stereo_t     hmix, hout;
  sample_t     tb_in, ret;
  int          fails, cmp_count, talk, tone, hpret, hpx;

  slate_tone_control #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(4), .IDENT_CYCLES(50)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_left(sw_l), .switch_right(sw_r), .select_encoder_held(enc),
    .transport_up(tp[0]), .transport_down(tp[1]), .talkback_led(tled), .tone_led(oled),
    .record_start(rec), .play_start(ply), .sample_valid(sample_valid), .program_in(prog),
    .headphone_mix(hmix), .talkback_in(tb_in), .return_feed_source(ret),
    .dest_out(dout), .aes_out(aout), .headphone_out(hout));
  operator_panel i_panel (.clk(clk), .pos(pos), .sw_l(sw_l), .sw_r(sw_r));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] pg(input int i);
    int s;
    s = int'($signed(prog.dest[i]));
    if (hpx != 0 && i == DST_AUX_THIRD)
      s += int'($signed(hmix.left));
    if (hpx != 0 && i == DST_AUX_FOURTH)
      s += int'($signed(hmix.right));
    if (s > 32767)
      s = 32767;
    if (s < -32768)
      s = -32768;
    return 16'(s);
  endfunction
  task automatic close_out();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      fails++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic frame();
    @(posedge clk);
    sample_valid  <= 1'b1;
    prog          <= {xs(), xs(), xs(), xs(), xs(), xs()};
    {tb_in, ret}  <= xs();
    hmix          <= xs();
    @(posedge clk);
    sample_valid <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < NDEST; i++)
      if (!(tone && tmask[i]))
      begin
        chk(dout.dest[i], (talk && smask[i]) ? tb_in : pg(i));
        chk(aout.dest[i], pg(i));
      end
      else
        chk(aout.dest[i], dout.dest[i]);
    if (talk)
      chk(hout, {tb_in, tb_in});
    else if (hpret)
      chk(hout, {ret, ret});
    else if (!tone)
      chk(hout, hmix);
  endtask
  task automatic slide(input logic [1:0] p, input int hold, input int on, input int off);
    pos <= p;
    repeat (20) @(posedge clk);
    chk((p == 2'h1) ? tled : oled, on);
    repeat (hold) @(posedge clk);
    pos <= 2'h0;
    repeat (20) @(posedge clk);
    chk((p == 2'h1) ? tled : oled, off);
  endtask
  task automatic tport(input int k);
    int n;
    n = 0;
    tp[k] <= 1'b1;
    repeat (30)
    begin
      @(posedge clk);
      n += int'(k ? ply : rec);
    end
    tp[k] <= 1'b0;
    chk(n, 1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    close_out();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, sample_valid, enc, pos, tp} = 10'h000;
    {paddr, pwdata, prog, hmix, tb_in, ret} = '0;
    {fails, cmp_count, talk, tone, hpret, hpx} = '0;
    seed = 32'h67bd4a0f;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_FREQ, 32'h64);
    rdchk(ADDR_SLATE_MASK, 32'h03f);
    rdchk(ADDR_TONE_MASK, 32'hfff);
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(12'h100, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1f);
    rdchk(ADDR_CTRL, 32'h14);
    apb(1'b1, ADDR_FREQ, 32'h5);
    rdchk(ADDR_FREQ, 32'ha);
    apb(1'b1, ADDR_FREQ, 32'h3ff);
    rdchk(ADDR_FREQ, 32'h3e8);
    smask = 12'(xs());
    tmask = 12'(xs());
    apb(1'b1, ADDR_SLATE_MASK, 32'(smask));
    rdchk(ADDR_SLATE_MASK, 32'(smask));
    apb(1'b1, ADDR_TONE_MASK, 32'(tmask));
    rdchk(ADDR_TONE_MASK, 32'(tmask));
    frame();
    talk = 1;
    slide(2'h1, 0, 1, 1);
    frame();
    talk = 0;
    slide(2'h1, 0, 0, 0);
    slide(2'h1, HOLD + 20, 1, 0);
    slide(2'h2, 0, 1, 0);
    enc <= 1'b1;
    slide(2'h2, HOLD, 1, 1);
    enc <= 1'b0;
    tone = 1;
    rdchk(ADDR_STATUS, 32'he);
    frame();
    hpret = 1;
    hpx = 1;
    apb(1'b1, ADDR_CTRL, 32'h1c0);
    rdchk(ADDR_CTRL, 32'h1c0);
    frame();
    tone = 0;
    slide(2'h2, 0, 0, 0);
    frame();
    hpret = 0;
    hpx = 0;
    apb(1'b1, ADDR_CTRL, 32'h20);
    rdchk(ADDR_CTRL, 32'h20);
    slide(2'h2, HOLD, 1, 1);
    rdchk(ADDR_STATUS, 32'he);
    slide(2'h2, 0, 0, 0);
    for (int k = 0; k < 2; k++)
      tport(k);
    close_out();
  end
endmodule
